// file: rtl/smi_status_map.svh
// register indices, reset values and bit masks of the smi status bank
`ifndef SMI_STATUS_MAP_SVH
`define SMI_STATUS_MAP_SVH

// register indices; byte address is four times the index
`define SMI_IDX_STATUS_ONE    8'h10
`define SMI_IDX_STATUS_TWO    8'h11
`define SMI_IDX_STATUS_THREE  8'h12
`define SMI_IDX_STATUS_FOUR   8'h13
`define SMI_IDX_STATUS_FIVE   8'h14
`define SMI_IDX_STATUS_SIX    8'h15
`define SMI_IDX_ENABLE_ONE    8'h16
`define SMI_IDX_ENABLE_SIX    8'h1B

// counts and widths
`define SMI_NUM_STATUS        6
`define SMI_NUM_REGS          12
`define SMI_SRC_BITS          48
`define SMI_SLOT_NONE         4'hF

// reset values
`define SMI_RST_STATUS_ONE    8'h02
`define SMI_RST_STATUS        8'h00
`define SMI_RST_ENABLE        8'h00

// bits that follow their source level
`define SMI_LIVE_ONE          8'h9E
`define SMI_LIVE_TWO          8'h03
// write-one-to-clear bits
`define SMI_W1C_TWO           8'h1C
`define SMI_W1C_ALL           8'hFF
// parallel-port fields inside the first status byte
`define SMI_PP_IRQ_BIT        1
`define SMI_PP_ACT_BIT        0
// writable enable bits
`define SMI_EN_ONE_MASK       8'h9E
`define SMI_EN_TWO_MASK       8'hDF
`define SMI_EN_ALL_MASK       8'hFF
// enable-two: bits that gate sources, and the output enable bit
`define SMI_EN_TWO_SRC        8'h1F
`define SMI_EN_PIN_BIT        7

`endif

// file: rtl/smi_status_pkg.sv
// types of the smi status bank
`include "smi_status_map.svh"
package smi_status_pkg;

    typedef logic [`SMI_NUM_STATUS-1:0][7:0] byte_bank_t;

    typedef struct packed {
        logic [`SMI_SRC_BITS-1:0] sync1;
        logic [`SMI_SRC_BITS-1:0] sync2;
        byte_bank_t               sts;
        byte_bank_t               en;
        logic [31:0]              rdata;
        logic                     irq;
    } state_t;

endpackage

// file: rtl/smi_status_bank.sv
// smi status bank with apb register port and combined smi output
//
// What this block does
// - the first status register resets to 0x02 with the parallel-port bit set.
// - first status bits 1,2,3,4,7 show parallel, midi, serial, floppy, watchdog live; 0,5,6 reserved.
// - while the parallel port is not activated its status bit reads one.
// - while the parallel port is activated its status bit follows the acknowledge input.
// - second status bits 0 and 1 show mouse and keyboard live; bits 5 to 7 reserved.
// - second status bits 2,3,4 (smbus, ring, port output) reset to zero and clear on a one write.
// - clearing a sticky bit does not clear its source, so a still active source sets it again.
// - third status register resets to zero and maps pins 20-22, 60, 24-27 to bits 0-7.
// - every bit of status three to six clears on a written one and ignores a written zero.
// - fourth status maps pins 30-33, 41, fan_tachometer_event, 43, 61 to bits 0-7.
// - fifth status maps pins 50-57 to bits 0-7.
// - sixth status maps pins 10-17 to bits 0-7.
// - a status bit reaches the smi output only when its enable bit is one, yet always records.
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
module smi_status_bank (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // first status sources
    input  wire logic        pp_activate,
    input  wire logic        pp_ack_n,
    input  wire logic        midi_uart_irq,
    input  wire logic        serial_uart_irq,
    input  wire logic        floppy_irq,
    input  wire logic        watchdog_irq,
    // second status sources
    input  wire logic        mouse_irq,
    input  wire logic        keyboard_irq,
    input  wire logic        smbus_event,
    input  wire logic        ring_indicate_event,
    input  wire logic        kbd_port_output_event,
    // general pins and fan
    input  wire logic [7:0]  general_pin_group_one,
    input  wire logic [7:0]  general_pin_group_two,
    input  wire logic [3:0]  general_pin_group_three,
    input  wire logic        general_pin_forty_one,
    input  wire logic        general_pin_forty_three,
    input  wire logic [7:0]  general_pin_group_five,
    input  wire logic        general_pin_sixty,
    input  wire logic        general_pin_sixty_one,
    input  wire logic        fan_tachometer_event,
    // combined interrupt, active high
    output logic             combined_smi_output
);

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    function automatic logic [3:0] reg_slot(input logic [11:0] addr);
        logic [7:0] idx;
        idx = addr[9:2];
        if (addr[1:0] != 2'h0 || addr[11:10] != 2'h0 ||
            idx < `SMI_IDX_STATUS_ONE || idx > `SMI_IDX_ENABLE_SIX) begin
            return `SMI_SLOT_NONE;
        end
        return 4'(idx - `SMI_IDX_STATUS_ONE);
    endfunction

    function automatic logic [7:0] en_mask(input int unsigned n);
        if (n == 0) begin
            return `SMI_EN_ONE_MASK;
        end
        if (n == 1) begin
            return `SMI_EN_TWO_MASK;
        end
        return `SMI_EN_ALL_MASK;
    endfunction

    smi_status_pkg::state_t q;
    smi_status_pkg::state_t d;

    logic [`SMI_SRC_BITS-1:0] raw;
    logic [3:0]               slot;
    logic                     wr_acc;
    logic                     rd_setup;
    logic [7:0]               pend;

    assign slot     = reg_slot(paddr);
    assign wr_acc   = psel && penable && pwrite && (slot != `SMI_SLOT_NONE);
    assign rd_setup = psel && !penable && !pwrite;

    // ----------------------------------------------------------------
    // source layout, one byte per status register
    // ----------------------------------------------------------------
    assign raw = {
        general_pin_group_one,
        general_pin_group_five,
        general_pin_sixty_one,
        general_pin_forty_three,
        fan_tachometer_event,
        general_pin_forty_one,
        general_pin_group_three,
        general_pin_group_two[7:4],
        general_pin_sixty,
        general_pin_group_two[2:0],
        3'h0,
        kbd_port_output_event,
        ring_indicate_event,
        smbus_event,
        keyboard_irq,
        mouse_irq,
        watchdog_irq,
        2'h0,
        floppy_irq,
        serial_uart_irq,
        midi_uart_irq,
        pp_ack_n,
        pp_activate
    };

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [`SMI_NUM_STATUS-1:0][7:0] src;
        logic [7:0] clr;
        logic [7:0] w1c;
        logic [7:0] live;
        d    = q;
        src  = q.sync2;
        clr  = 8'h00;
        w1c  = 8'h00;
        live = 8'h00;
        pend = 8'h00;
        d.sync1 = raw;
        d.sync2 = q.sync1;
        for (int unsigned i = 0; i < `SMI_NUM_STATUS; i++) begin
            unique case (i)
                0: begin
                    live = `SMI_LIVE_ONE;
                    w1c  = 8'h00;
                end
                1: begin
                    live = `SMI_LIVE_TWO;
                    w1c  = `SMI_W1C_TWO;
                end
                default: begin
                    live = 8'h00;
                    w1c  = `SMI_W1C_ALL;
                end
            endcase
            clr = (wr_acc && slot == 4'(i)) ? pwdata[7:0] : 8'h00;
            d.sts[i] = (src[i] & live) |
                       (((q.sts[i] & ~clr) | src[i]) & w1c);
        end
        d.sts[0][`SMI_PP_IRQ_BIT] = q.sync2[`SMI_PP_ACT_BIT] ?
                                    q.sync2[`SMI_PP_IRQ_BIT] : 1'b1;
        for (int unsigned i = 0; i < `SMI_NUM_STATUS; i++) begin
            if (wr_acc && slot == 4'(i + `SMI_NUM_STATUS)) begin
                d.en[i] = pwdata[7:0] & en_mask(i);
            end
        end
        for (int unsigned i = 0; i < `SMI_NUM_STATUS; i++) begin
            pend = pend | (q.sts[i] & q.en[i] &
                   ((i == 1) ? `SMI_EN_TWO_SRC : en_mask(i)));
        end
        d.irq = q.en[1][`SMI_EN_PIN_BIT] && (pend != 8'h00);
        if (rd_setup) begin
            d.rdata = 32'h0000_0000;
            if (slot < 4'(`SMI_NUM_STATUS)) begin
                d.rdata[7:0] = q.sts[slot[2:0]];
            end else if (slot < 4'(`SMI_NUM_REGS)) begin
                d.rdata[7:0] = q.en[3'(slot - 4'(`SMI_NUM_STATUS))];
            end
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q       <= '0;
            q.sts[0] <= `SMI_RST_STATUS_ONE;
            q.sts[1] <= `SMI_RST_STATUS;
            q.en    <= {`SMI_NUM_STATUS{`SMI_RST_ENABLE}};
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------------------------------
    // bus response and interrupt output
    // ----------------------------------------------------------------
    assign prdata              = q.rdata;
    assign pready              = 1'b1;
    assign pslverr             = psel && penable &&
                                 (slot == `SMI_SLOT_NONE);
    assign combined_smi_output = q.irq;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_pp_idle_high: assert property (
        !q.sync2[`SMI_PP_ACT_BIT] |=> q.sts[0][`SMI_PP_IRQ_BIT])
        else $error("parallel bit not one while idle");

    a_pp_ack_track: assert property (
        q.sync2[`SMI_PP_ACT_BIT] |=>
        q.sts[0][`SMI_PP_IRQ_BIT] == $past(q.sync2[`SMI_PP_IRQ_BIT]))
        else $error("parallel bit not following ack");

    a_live_one_follow: assert property (
        1'b1 |=> q.sts[0][7] == $past(q.sync2[7]) &&
                 q.sts[0][4:2] == $past(q.sync2[4:2]))
        else $error("live source bit wrong");

    a_live_two_follow: assert property (
        1'b1 |=> q.sts[1][1:0] == $past(q.sync2[9:8]))
        else $error("mouse or keyboard bit wrong");

    a_reserved_zero: assert property (
        q.sts[0][0] == 1'b0 && q.sts[0][6:5] == 2'h0 &&
        q.sts[1][7:5] == 3'h0)
        else $error("reserved status bit set");

    a_set_wins: assert property (
        q.sync2[10] |=> q.sts[1][2])
        else $error("smbus event lost");

    a_w1c_clears: assert property (
        wr_acc && slot == 4'h2 && pwdata[0] && !q.sync2[16]
        |=> !q.sts[2][0])
        else $error("written one did not clear");

    a_w1c_holds: assert property (
        q.sts[3][5] && !(wr_acc && slot == 4'h3 && pwdata[5])
        |=> q.sts[3][5])
        else $error("sticky fan bit dropped");

    a_pin_sixty_map: assert property (
        q.sync2[19] |=> q.sts[2][3])
        else $error("pin sixty not latched");

    a_group_maps: assert property (
        q.sync2[32] && q.sync2[47] |=> q.sts[4][0] && q.sts[5][7])
        else $error("group five or one not latched");

    a_smi_gated: assert property (
        (q.en[1][`SMI_EN_PIN_BIT] == 1'b0) [*2] |-> !combined_smi_output)
        else $error("smi output without enable");

    a_one_no_clear: assert property (
        wr_acc && slot == 4'h0 && q.sync2[4]
        |=> q.sts[0][4])
        else $error("write cleared a source-held bit");

    a_two_live_kept: assert property (
        wr_acc && slot == 4'h1 && q.sync2[9]
        |=> q.sts[1][1])
        else $error("write cleared keyboard bit");

    a_two_sticky_set: assert property (
        1'b1 |=> (q.sts[1][4:2] & $past(q.sync2[12:10])) ==
                 $past(q.sync2[12:10]))
        else $error("second status event not latched");

    a_ring_clear: assert property (
        wr_acc && slot == 4'h1 && pwdata[3] && !q.sync2[11]
        |=> !q.sts[1][3])
        else $error("ring bit not cleared");

    a_port_out_clear: assert property (
        wr_acc && slot == 4'h1 && pwdata[4] && !q.sync2[12]
        |=> !q.sts[1][4])
        else $error("port output bit not cleared");

    a_two_zero_keep: assert property (
        q.sts[1][4] && !(wr_acc && slot == 4'h1 && pwdata[4])
        |=> q.sts[1][4])
        else $error("port output bit dropped");

    a_clear_refires: assert property (
        wr_acc && slot == 4'h1 && pwdata[3] && q.sync2[11]
        |=> q.sts[1][3])
        else $error("active source lost on clear");

    a_three_latch: assert property (
        1'b1 |=> (q.sts[2] & $past(q.sync2[23:16])) ==
                 $past(q.sync2[23:16]))
        else $error("third status event not latched");

    a_four_latch: assert property (
        1'b1 |=> (q.sts[3] & $past(q.sync2[31:24])) ==
                 $past(q.sync2[31:24]))
        else $error("fourth status event not latched");

    a_five_latch: assert property (
        1'b1 |=> (q.sts[4] & $past(q.sync2[39:32])) ==
                 $past(q.sync2[39:32]))
        else $error("fifth status event not latched");

    a_six_latch: assert property (
        1'b1 |=> (q.sts[5] & $past(q.sync2[47:40])) ==
                 $past(q.sync2[47:40]))
        else $error("sixth status event not latched");

    a_zero_write_keep: assert property (
        q.sts[5][3] && wr_acc && slot == 4'h5 && !pwdata[3]
        |=> q.sts[5][3])
        else $error("written zero cleared a bit");

    a_four_clear: assert property (
        wr_acc && slot == 4'h3 && pwdata[5] && !q.sync2[29]
        |=> !q.sts[3][5])
        else $error("fan bit not cleared");

    a_five_clear: assert property (
        wr_acc && slot == 4'h4 && pwdata[0] && !q.sync2[32]
        |=> !q.sts[4][0])
        else $error("fifth status bit not cleared");

    a_six_clear: assert property (
        wr_acc && slot == 4'h5 && pwdata[2] && !q.sync2[42]
        |=> !q.sts[5][2])
        else $error("sixth status bit not cleared");

    a_irq_off_idle: assert property (
        pend == 8'h00
        |=> !combined_smi_output)
        else $error("smi output with nothing pending");

    a_irq_on_pend: assert property (
        q.en[1][`SMI_EN_PIN_BIT] && pend != 8'h00
        |=> combined_smi_output)
        else $error("smi output missing");

    a_masked_records: assert property (
        q.sync2[40] && !q.en[5][0]
        |=> q.sts[5][0])
        else $error("masked event not recorded");

    a_pin_gate_off: assert property (
        !q.en[1][`SMI_EN_PIN_BIT]
        |=> !combined_smi_output)
        else $error("smi output while pin disabled");

    a_two_reserved_wr: assert property (
        wr_acc && slot == 4'h1
        |=> q.sts[1][7:5] == 3'h0)
        else $error("reserved bit took a write");

    // ----------------------------------------------------------------
    // cover points
    // ----------------------------------------------------------------
    c_w1c_clear: cover property (wr_acc && slot == 4'h4 &&
                                 pwdata[7:0] != 8'h00);
    c_smi_fire: cover property (!combined_smi_output ##1 combined_smi_output);
    c_pp_active: cover property (q.sync2[`SMI_PP_ACT_BIT] ##1
                                 !q.sts[0][`SMI_PP_IRQ_BIT]);
    c_bad_addr: cover property (pslverr);
    c_refire: cover property (wr_acc && slot == 4'h1 && q.sync2[11]);

endmodule // smi_status_bank

// file: test/apb_host_model.sv
// apb master model standing in for the host chipset
`timescale 1ns/1ps
module apb_host_model (
    // clock
    input  wire logic        pclk,
    // apb master side
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [11:0] paddr,
    output logic      [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial begin
        {psel, penable, pwrite} <= 3'h0;
        paddr  <= 12'h000;
        pwdata <= 32'h0;
    end

    // setup cycle, then access until pready seen high
    task automatic xfer(input logic wr, input logic [11:0] addr,
                        input logic [31:0] wd, output logic [31:0] rd,
                        output logic err);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= addr;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'h0;
        // released address and data lines show the inverse of their last values
        paddr  <= ~addr;
        pwdata <= ~wd;
    endtask
endmodule // apb_host_model

// file: test/smi_status_bank_test.sv
// self-checking bench of the smi status bank
`timescale 1ns/1ps
`include "smi_status_map.svh"
module smi_status_bank_test;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic        pp_activate, pp_ack_n, midi_uart_irq, serial_uart_irq;
    logic        floppy_irq, watchdog_irq, mouse_irq, keyboard_irq;
    logic        smbus_event, ring_indicate_event, kbd_port_output_event;
    logic        general_pin_forty_one, general_pin_forty_three;
    logic        general_pin_sixty, general_pin_sixty_one;
    logic        fan_tachometer_event, combined_smi_output;
    logic [7:0]  general_pin_group_one, general_pin_group_two;
    logic [7:0]  general_pin_group_five;
    logic [3:0]  general_pin_group_three;
    int          fail_count = 0;
    int          check_count = 0;

    smi_status_bank smi_status_bank_inst (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .pp_activate, .pp_ack_n,
        .midi_uart_irq, .serial_uart_irq, .floppy_irq, .watchdog_irq,
        .mouse_irq, .keyboard_irq, .smbus_event, .ring_indicate_event,
        .kbd_port_output_event, .general_pin_group_one,
        .general_pin_group_two, .general_pin_group_three,
        .general_pin_forty_one, .general_pin_forty_three,
        .general_pin_group_five, .general_pin_sixty,
        .general_pin_sixty_one, .fan_tachometer_event, .combined_smi_output
    );
    apb_host_model apb_host_model_inst (
        .pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr
    );

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic wr(logic [7:0] idx, logic [7:0] d);
        logic [31:0] r;
        logic        e;
        apb_host_model_inst.xfer(1'b1, {2'b00, idx, 2'b00}, {24'h0, d}, r, e);
    endtask
    task automatic rd_chk(string n, logic [7:0] idx, logic [31:0] exp,
                          logic exp_err = 1'b0);
        logic [31:0] r;
        logic        e;
        apb_host_model_inst.xfer(1'b0, {2'b00, idx, 2'b00}, 32'h0, r, e);
        chk(n, r, exp);
        chk({n, "_err"}, {31'h0, e}, {31'h0, exp_err});
    endtask
    task automatic zero_src;
        {pp_activate, pp_ack_n, midi_uart_irq, serial_uart_irq, floppy_irq,
         watchdog_irq, mouse_irq, keyboard_irq, smbus_event,
         ring_indicate_event, kbd_port_output_event, general_pin_forty_one,
         general_pin_forty_three, general_pin_sixty, general_pin_sixty_one,
         fan_tachometer_event, general_pin_group_one, general_pin_group_two,
         general_pin_group_five, general_pin_group_three} <= '0;
    endtask
    task automatic irq_chk(string n, logic exp);
        repeat (3) @(negedge pclk);
        chk(n, {31'h0, combined_smi_output}, {31'h0, exp});
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset;
        rd_chk("status_one", `SMI_IDX_STATUS_ONE, 32'h02);
        for (int i = 1; i < 6; i++)
            rd_chk("status_n", 8'(`SMI_IDX_STATUS_ONE + i), 32'h0);
        rd_chk("unmapped", 8'hFF, 32'h0, 1'b1);
        $display("test reset done");
    endtask
    task automatic t_status_one;
        pp_activate <= 1'b1;
        midi_uart_irq <= 1'b1;
        tick(4);
        rd_chk("pp_ack_low", `SMI_IDX_STATUS_ONE, 32'h04);
        {pp_activate, midi_uart_irq} <= 2'b00;
        {serial_uart_irq, floppy_irq, watchdog_irq} <= 3'b111;
        tick(4);
        rd_chk("pp_idle", `SMI_IDX_STATUS_ONE, 32'h9A);
        wr(`SMI_IDX_STATUS_ONE, 8'hFF);
        rd_chk("status_one_ro", `SMI_IDX_STATUS_ONE, 32'h9A);
        zero_src();
        tick(1);
        pp_activate <= 1'b1;
        pp_ack_n <= 1'b1;
        tick(4);
        rd_chk("pp_ack_high", `SMI_IDX_STATUS_ONE, 32'h02);
        $display("test status one done");
    endtask
    task automatic t_status_two;
        {mouse_irq, smbus_event, ring_indicate_event} <= 3'b111;
        tick(4);
        {mouse_irq, smbus_event} <= 2'b00;
        tick(4);
        rd_chk("sticky", `SMI_IDX_STATUS_TWO, 32'h0C);
        wr(`SMI_IDX_STATUS_TWO, 8'hFF);
        rd_chk("src_held", `SMI_IDX_STATUS_TWO, 32'h08);
        {keyboard_irq, kbd_port_output_event} <= 2'b11;
        ring_indicate_event <= 1'b0;
        tick(4);
        kbd_port_output_event <= 1'b0;
        rd_chk("live_two", `SMI_IDX_STATUS_TWO, 32'h1A);
        wr(`SMI_IDX_STATUS_TWO, 8'h18);
        rd_chk("w1c_two", `SMI_IDX_STATUS_TWO, 32'h02);
        zero_src();
        tick(1);
        $display("test status two done");
    endtask
    task automatic t_pins;
        general_pin_group_two <= 8'h5A;
        general_pin_group_three <= 4'h9;
        {general_pin_forty_one, general_pin_forty_three} <= 2'b11;
        general_pin_group_five <= 8'hC3;
        general_pin_group_one <= 8'h3C;
        tick(4);
        zero_src();
        tick(1);
        {fan_tachometer_event, general_pin_sixty} <= 2'b11;
        general_pin_sixty_one <= 1'b1;
        tick(4);
        zero_src();
        tick(4);
        rd_chk("status_three", `SMI_IDX_STATUS_THREE, 32'h5A);
        rd_chk("status_four", `SMI_IDX_STATUS_FOUR, 32'hF9);
        rd_chk("status_five", `SMI_IDX_STATUS_FIVE, 32'hC3);
        rd_chk("status_six", `SMI_IDX_STATUS_SIX, 32'h3C);
        wr(`SMI_IDX_STATUS_SIX, 8'h00);
        rd_chk("zero_write", `SMI_IDX_STATUS_SIX, 32'h3C);
        wr(`SMI_IDX_STATUS_SIX, 8'h04);
        rd_chk("one_bit", `SMI_IDX_STATUS_SIX, 32'h38);
        for (int i = 2; i < 6; i++) begin
            wr(8'(`SMI_IDX_STATUS_ONE + i), 8'hFF);
            rd_chk("w1c_all", 8'(`SMI_IDX_STATUS_ONE + i), 32'h0);
        end
        $display("test pins done");
    endtask
    task automatic t_irq;
        general_pin_group_one <= 8'h01;
        tick(4);
        general_pin_group_one <= 8'h00;
        wr(`SMI_IDX_ENABLE_SIX, 8'h01);
        irq_chk("pin_gate_off", 1'b0);
        wr(8'(`SMI_IDX_ENABLE_ONE + 1), 8'h80);
        irq_chk("raised", 1'b1);
        wr(`SMI_IDX_ENABLE_SIX, 8'h00);
        irq_chk("masked", 1'b0);
        rd_chk("recorded", `SMI_IDX_STATUS_SIX, 32'h01);
        wr(`SMI_IDX_ENABLE_SIX, 8'h01);
        irq_chk("unmasked", 1'b1);
        wr(`SMI_IDX_STATUS_SIX, 8'h01);
        irq_chk("cleared", 1'b0);
        $display("test irq done");
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    initial begin
        #(25 * 20000);
        fail_count++;
        print_verdict();
    end
    initial begin
        presetn <= 1'b0;
        zero_src();
        tick(12);
        presetn <= 1'b1;
        t_reset();
        t_status_one();
        t_status_two();
        t_pins();
        t_irq();
        print_verdict();
    end
endmodule // smi_status_bank_test
